/* File: sss_defs.vh */
// Purpose: constants for the system start sequencer
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times in ns or us, cycle counts derived from them
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH
`define SSS_CLK_PERIOD_NS     8
`define SSS_SETTLE_TMO_US     1500
`define SSS_SETTLE_TMO_CYC    ((`SSS_SETTLE_TMO_US * 1000) / `SSS_CLK_PERIOD_NS)
`define SSS_PROBE_TMO_US      1000
`define SSS_PROBE_TMO_CYC     ((`SSS_PROBE_TMO_US * 1000) / `SSS_CLK_PERIOD_NS)
`define SSS_APP_FLAG          64'hA5A51234A5A51234
`define SSS_CAL_VALID         16'hA5A5
`define SSS_FLASH_WAKE_DEF    8'hAB
`define SSS_LAST_STEP         4'hA
`define SSS_SLAVE_STEP        4'h6
`define SSS_SLAVE_LOOPS       2'h3
`define SSS_FIFO_DEPTH        4
`define SSS_WORD_W            32
`define SSS_CNT_W             16
`define SSS_MODE_NORMAL       2'h1
`define SSS_MODE_DEV          2'h2
`define SSS_MODE_FAULT        2'h3
`endif

/* File: sss_fifo.v */
// Purpose: small word fifo between copy source and ram writer
// Assumes: single clock
// Notes:   full and empty are exact
module sss_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_clk,
  input  wire             i_rst_b,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;
  assign o_in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign o_out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;
  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_reg  <= {AW{1'b0}};
      rd_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      if (push & ~pop) cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push) cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // sss_fifo

/* File: sss_top.v */
// Purpose: power/wake-up sequencer, wake-up otp copy engine, boot path selector
// Assumes: inputs synchronous to i_clk; otp read and ram write are simple handshakes
// Notes:
// Notes on behaviour
// - run power stage, then memory copy stage on wake-up or boot stage on cold start
// - cold-start flag set to one on initial power-up
// - power sequence starts on every cold power-up and every wake-up
// - comparators pick buck or boost supply mode automatically
// - test boost comparator first; then enable bandgap and digital regulator
// - start crystal oscillator while re-checking and overwriting converter mode
// - poll settled signals; on timeout ignore them and continue
// - timeout inhibit bit makes sequencer wait for settled signals forever
// - hand over to boot on cold start, to copy on programmed wake-up
// - copy enable bit gates the wake-up memory copy
// - on wake-up no boot; hardware copies memory to ram before cpu
// - word count loaded once, retained, exactly that many words copied
// - boot path only after power-up or hardware reset
// - flag match normal, zeros development, else fault with peripherals on
// - development search runs eleven steps 0 to 10 in fixed order
// - each step routes its interface to fixed first-port pins
// - uart steps 8-N-1 at 57600, 115200, 57600, 9600 baud
// - spi slave step repeated four times at 8, 4, 2, 1 MHz
// - i2c steps use standard-mode clock rate
// - each step sends probe, waits reply; timeout moves on, reply runs loader
// - user spi config skips other paths; on failure standard search runs
// - normal mode writes header config; calibration upper half holds validity
// - application flag recognised only at its exact 64-bit pattern
// - flash wake opcode is configured value or default when unprogrammed
`include "sss_defs.vh"
module sss_top #(
  parameter SETTLE_TMO_CYC = `SSS_SETTLE_TMO_CYC,
  parameter PROBE_TMO_CYC  = `SSS_PROBE_TMO_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_wakeup,
  input  wire        i_cmp_high_battery,
  input  wire        i_cmp_low_battery,
  input  wire        i_ldo_settled,
  input  wire        i_xtal_settled,
  input  wire        i_timeout_inhibit,
  input  wire        i_otp_copy_en,
  input  wire        i_word_count_load,
  input  wire [15:0] i_word_count,
  output reg         o_otp_rd_req,
  output reg  [15:0] o_otp_rd_addr,
  input  wire        i_otp_rd_valid,
  input  wire [31:0] i_otp_rd_data,
  output reg         o_ram_wr_valid,
  output reg  [15:0] o_ram_wr_addr,
  output reg  [31:0] o_ram_wr_data,
  input  wire        i_ram_wr_ready,
  input  wire [63:0] i_app_flag,
  input  wire [31:0] i_cal_flags,
  input  wire        i_user_spi_sel,
  input  wire [7:0]  i_flash_wake_opc,
  input  wire        i_flash_wake_prog,
  input  wire        i_probe_reply,
  input  wire        i_loader_done,
  input  wire        i_loader_fail,
  output reg         o_dcdc_en,
  output reg         o_dcdc_boost,
  output reg         o_bandgap_en,
  output reg         o_ldo_en,
  output reg         o_xtal_en,
  output reg         o_cold_start,
  output reg         o_cpu_run,
  output reg         o_boot_active,
  output reg  [1:0]  o_boot_mode,
  output reg         o_periph_en,
  output reg         o_hdr_cfg_wr,
  output reg         o_cal_valid,
  output reg  [7:0]  o_flash_wake_opc,
  output reg         o_user_spi_active,
  output reg  [3:0]  o_search_step,
  output reg  [1:0]  o_slave_iter,
  output reg  [2:0]  o_if_sel,
  output reg  [7:0]  o_pin_map,
  output reg  [17:0] o_rate_kbd,
  output reg         o_probe_send,
  output reg         o_loader_run
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [8:0] S_IDLE  = 9'h001;
  localparam [8:0] S_SUPPLY = 9'h002;
  localparam [8:0] S_REG   = 9'h004;
  localparam [8:0] S_SETTLE = 9'h008;
  localparam [8:0] S_COPY  = 9'h010;
  localparam [8:0] S_BOOT  = 9'h020;
  localparam [8:0] S_PROBE = 9'h040;
  localparam [8:0] S_LOAD  = 9'h080;
  localparam [8:0] S_RUN   = 9'h100;
  localparam [2:0] IF_SPIM = 3'h1;
  localparam [2:0] IF_UART = 3'h2;
  localparam [2:0] IF_SPIS = 3'h3;
  localparam [2:0] IF_I2C  = 3'h4;

  // interface, pin pairs {clk/tx, cs/rx} as port-0 indices, rate in baud for uart, khz otherwise
  function [28:0] step_cfg;
    input [3:0] s;
    input [1:0] it;
    begin
      case (s)
        4'h0: step_cfg = {IF_SPIM, 8'h03, 18'h00000};
        4'h1: step_cfg = {IF_SPIM, 8'h01, 18'h00000};
        4'h2: step_cfg = {IF_UART, 8'h01, 18'h0E100};
        4'h3: step_cfg = {IF_UART, 8'h23, 18'h1C200};
        4'h4: step_cfg = {IF_UART, 8'h45, 18'h0E100};
        4'h5: step_cfg = {IF_UART, 8'h67, 18'h02580};
        4'h6: step_cfg = {IF_SPIS, 8'h03, 18'h01F40 >> it};
        4'h7: step_cfg = {IF_I2C,  8'h01, 18'h00064};
        4'h8: step_cfg = {IF_I2C,  8'h23, 18'h00064};
        4'h9: step_cfg = {IF_I2C,  8'h45, 18'h00064};
        4'hA: step_cfg = {IF_I2C,  8'h67, 18'h00064};
        default: step_cfg = {3'h0, 8'h00, 18'h00000};
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [8:0]  st_reg;
  reg [31:0] tmo_reg;
  reg        cold_reg;
  reg        started_reg;
  reg [15:0] nwords_reg;
  reg [15:0] rd_cnt_reg;
  reg [15:0] wr_cnt_reg;
  reg        user_spi_reg;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire       settled;
  wire       tmo_hit;
  wire [28:0] cfg;

  assign settled = i_ldo_settled & i_xtal_settled;
  assign tmo_hit = (tmo_reg == 32'h00000000);
  assign cfg     = step_cfg(o_search_step, o_slave_iter);

  // back-pressure: fifo stalls reads while full
  sss_fifo #(.WIDTH(`SSS_WORD_W), .DEPTH(`SSS_FIFO_DEPTH), .AW(2)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (i_otp_rd_valid & (st_reg == S_COPY)),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_otp_rd_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (~o_ram_wr_valid | i_ram_wr_ready),
    .o_out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // retained word count, loaded by boot software once
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nwords_reg <= 16'h0000;
    end else if (i_word_count_load) begin
      nwords_reg <= i_word_count;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg            <= S_SUPPLY;
      cold_reg          <= 1'b1;
      started_reg       <= 1'b0;
      tmo_reg           <= 32'h00000000;
      rd_cnt_reg        <= 16'h0000;
      wr_cnt_reg        <= 16'h0000;
      user_spi_reg      <= 1'b0;
      o_otp_rd_req      <= 1'b0;
      o_otp_rd_addr     <= 16'h0000;
      o_ram_wr_valid    <= 1'b0;
      o_ram_wr_addr     <= 16'h0000;
      o_ram_wr_data     <= 32'h00000000;
      o_dcdc_en         <= 1'b0;
      o_dcdc_boost      <= 1'b0;
      o_bandgap_en      <= 1'b0;
      o_ldo_en          <= 1'b0;
      o_xtal_en         <= 1'b0;
      o_cold_start      <= 1'b1;
      o_cpu_run         <= 1'b0;
      o_boot_active     <= 1'b0;
      o_boot_mode       <= 2'h0;
      o_periph_en       <= 1'b0;
      o_hdr_cfg_wr      <= 1'b0;
      o_cal_valid       <= 1'b0;
      o_flash_wake_opc  <= 8'h00;
      o_user_spi_active <= 1'b0;
      o_search_step     <= 4'h0;
      o_slave_iter      <= 2'h0;
      o_if_sel          <= 3'h0;
      o_pin_map         <= 8'h00;
      o_rate_kbd        <= 18'h00000;
      o_probe_send      <= 1'b0;
      o_loader_run      <= 1'b0;
    end else begin
      o_probe_send <= 1'b0;
      o_hdr_cfg_wr <= 1'b0;
      o_cold_start <= cold_reg;
      if (tmo_reg != 32'h00000000) tmo_reg <= tmo_reg - 32'h00000001;
      case (st_reg)
        S_IDLE: begin
          if (i_wakeup) begin
            st_reg    <= S_SUPPLY;
            o_cpu_run <= 1'b0;
          end
        end
        S_SUPPLY: begin
          o_dcdc_en <= 1'b1;
          if (i_cmp_low_battery) begin
            o_dcdc_boost <= 1'b1;
          end else begin
            o_dcdc_boost <= 1'b0;
          end
          st_reg <= S_REG;
        end
        S_REG: begin
          o_bandgap_en <= 1'b1;
          o_ldo_en     <= 1'b1;
          o_xtal_en    <= 1'b1;
          // second look at the comparators corrects a wrong first guess
          o_dcdc_boost <= i_cmp_low_battery & ~i_cmp_high_battery;
          tmo_reg      <= SETTLE_TMO_CYC;
          st_reg       <= S_SETTLE;
        end
        S_SETTLE: begin
          if (settled | (tmo_hit & ~i_timeout_inhibit)) begin
            if (cold_reg) begin
              st_reg <= S_BOOT;
            end else if (i_otp_copy_en && nwords_reg != 16'h0000) begin
              st_reg        <= S_COPY;
              rd_cnt_reg    <= 16'h0000;
              wr_cnt_reg    <= 16'h0000;
              o_otp_rd_addr <= 16'h0000;
              o_otp_rd_req  <= 1'b1;
            end else begin
              st_reg    <= S_RUN;
              o_cpu_run <= 1'b1;
            end
          end
        end
        S_COPY: begin
          if (i_otp_rd_valid & fifo_in_ready) begin
            rd_cnt_reg    <= rd_cnt_reg + 16'h0001;
            o_otp_rd_addr <= o_otp_rd_addr + 16'h0001;
            if (rd_cnt_reg + 16'h0001 == nwords_reg) o_otp_rd_req <= 1'b0;
          end
          if (o_ram_wr_valid & i_ram_wr_ready) begin
            wr_cnt_reg    <= wr_cnt_reg + 16'h0001;
            o_ram_wr_addr <= o_ram_wr_addr + 16'h0001;
          end
          if (~o_ram_wr_valid | i_ram_wr_ready) begin
            o_ram_wr_valid <= fifo_out_valid;
            o_ram_wr_data  <= fifo_out_data;
          end
          if (o_ram_wr_valid & i_ram_wr_ready & (wr_cnt_reg + 16'h0001 == nwords_reg)) begin
            o_ram_wr_valid <= 1'b0;
            o_ram_wr_addr  <= 16'h0000;
            st_reg         <= S_RUN;
            o_cpu_run      <= 1'b1;
          end
        end
        S_BOOT: begin
          cold_reg      <= 1'b0;
          o_boot_active <= 1'b1;
          o_cpu_run     <= 1'b1;
          o_flash_wake_opc <= i_flash_wake_prog ? i_flash_wake_opc
                                                : `SSS_FLASH_WAKE_DEF;
          if (i_app_flag == `SSS_APP_FLAG) begin
            o_boot_mode  <= `SSS_MODE_NORMAL;
            o_hdr_cfg_wr <= 1'b1;
            o_cal_valid  <= (i_cal_flags[31:16] == `SSS_CAL_VALID);
            st_reg       <= S_RUN;
          end else if (i_app_flag == 64'h0000000000000000) begin
            o_boot_mode   <= `SSS_MODE_DEV;
            o_periph_en   <= 1'b1;
            user_spi_reg  <= i_user_spi_sel;
            o_user_spi_active <= i_user_spi_sel;
            o_search_step <= 4'h0;
            o_slave_iter  <= 2'h0;
            st_reg        <= S_PROBE;
            started_reg   <= 1'b0;
          end else begin
            o_boot_mode <= `SSS_MODE_FAULT;
            o_periph_en <= 1'b1;
            st_reg      <= S_RUN;
          end
        end
        S_PROBE: begin
          if (!started_reg) begin
            started_reg  <= 1'b1;
            o_if_sel     <= user_spi_reg ? IF_SPIM : cfg[28:26];
            o_pin_map    <= cfg[25:18];
            o_rate_kbd   <= cfg[17:0];
            o_probe_send <= 1'b1;
            tmo_reg      <= PROBE_TMO_CYC;
          end else if (i_probe_reply) begin
            st_reg       <= S_LOAD;
            o_loader_run <= 1'b1;
          end else if (tmo_hit) begin
            started_reg <= 1'b0;
            if (user_spi_reg) begin
              user_spi_reg      <= 1'b0;
              o_user_spi_active <= 1'b0;
            end else if (o_search_step == `SSS_SLAVE_STEP &&
                         o_slave_iter != `SSS_SLAVE_LOOPS) begin
              o_slave_iter <= o_slave_iter + 2'h1;
            end else if (o_search_step == `SSS_LAST_STEP) begin
              o_search_step <= 4'h0;
              o_slave_iter  <= 2'h0;
            end else begin
              o_search_step <= o_search_step + 4'h1;
              o_slave_iter  <= 2'h0;
            end
          end
        end
        S_LOAD: begin
          if (i_loader_done) begin
            o_loader_run <= 1'b0;
            st_reg       <= S_RUN;
          end else if (i_loader_fail) begin
            o_loader_run <= 1'b0;
            started_reg  <= 1'b0;
            st_reg       <= S_PROBE;
            if (user_spi_reg) begin
              user_spi_reg      <= 1'b0;
              o_user_spi_active <= 1'b0;
            end
          end
        end
        S_RUN: begin
          // sleep entry is outside this block; a wake pulse restarts power-up
          if (i_wakeup) begin
            st_reg        <= S_SUPPLY;
            o_cpu_run     <= 1'b0;
            o_boot_active <= 1'b0;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule // sss_top

/* File: sss_top_props.sv */
// Purpose: concurrent checks on the start sequencer ports
// Assumes: one clock, async low reset
// Notes:   bounds carry a few cycles of slack over the settle count
`include "sss_defs.vh"
module sss_top_props #(
  parameter SETTLE_TMO_CYC = 40
) (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_cmp_low_battery,
  input wire logic        i_cmp_high_battery,
  input wire logic        i_timeout_inhibit,
  input wire logic        o_xtal_en,
  input wire logic        o_dcdc_boost,
  input wire logic        o_cold_start,
  input wire logic        o_cpu_run,
  input wire logic        o_boot_active,
  input wire logic [1:0]  o_boot_mode,
  input wire logic        o_periph_en,
  input wire logic        o_hdr_cfg_wr,
  input wire logic        o_otp_rd_req,
  input wire logic        o_user_spi_active,
  input wire logic [3:0]  o_search_step,
  input wire logic [1:0]  o_slave_iter,
  input wire logic [2:0]  o_if_sel,
  input wire logic [17:0] o_rate_kbd,
  input wire logic        o_loader_run
);
  localparam int SMAX = SETTLE_TMO_CYC + 12;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // --------
  // assertions
  // --------
  cold_clear_a: assert property ($rose(o_boot_active) |-> ##[0:1] !o_cold_start)
    else $error("cold flag kept in boot");
  boot_cold_a: assert property ($rose(o_boot_active) |-> $past(o_cold_start))
    else $error("boot without cold start");
  // a live high battery input means buck, whatever the low input says
  boost_mode_a: assert property ($rose(o_boot_active) |->
    o_dcdc_boost == (i_cmp_low_battery && !i_cmp_high_battery))
    else $error("converter mode wrong");
  stage_order_a: assert property ($rose(o_boot_active) || $rose(o_otp_rd_req) |-> o_xtal_en)
    else $error("stage before power stage");
  settle_bound_a: assert property ($rose(o_xtal_en) && !i_timeout_inhibit |->
    ##[1:SMAX] (o_boot_active || o_otp_rd_req || o_cpu_run))
    else $error("settle wait too long");
  step_order_a: assert property ($changed(o_search_step) && !o_user_spi_active
    && o_boot_mode == `SSS_MODE_DEV |-> o_search_step == (($past(o_search_step) == 4'hA)
    ? 4'h0 : $past(o_search_step) + 4'h1))
    else $error("search step out of order");
  // rate is reloaded one cycle after the iteration moves on
  slave_rate_a: assert property (o_if_sel == 3'h3 && $stable(o_slave_iter) |->
    o_rate_kbd == (18'h1F40 >> o_slave_iter))
    else $error("slave clock rate wrong");
  i2c_rate_a: assert property (o_if_sel == 3'h4 |-> o_rate_kbd == 18'h64)
    else $error("i2c rate wrong");
  fault_periph_a: assert property (o_boot_mode == `SSS_MODE_FAULT |-> ##[0:2] o_periph_en)
    else $error("peripherals off in fault");
  copy_warm_a: assert property (o_otp_rd_req |-> !o_boot_active && !o_cold_start)
    else $error("copy during cold boot");
  hdr_normal_a: assert property (o_hdr_cfg_wr |-> o_boot_mode == `SSS_MODE_NORMAL)
    else $error("header write outside normal");
  cover property (o_loader_run);
  cover property ($rose(o_otp_rd_req));
  cover property (o_hdr_cfg_wr);
  cover property (o_if_sel == 3'h3 && o_slave_iter == 2'h3);
endmodule // sss_top_props

/* File: sss_mem_model.sv */
// Purpose: otp word source and ram write sink for the copy engine
// Assumes: one clock; stall mode set by the bench
// Notes:   idle read data differs from valid data so stale captures show
module sss_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_slow,
  input  wire logic        i_rd_req,
  input  wire logic [15:0] i_rd_addr,
  output logic             o_rd_valid,
  output logic      [31:0] o_rd_data,
  input  wire logic        i_wr_valid,
  input  wire logic [15:0] i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  output logic             o_wr_ready,
  output int               o_wr_cnt
);
  logic [2:0]  cyc_reg;
  logic        req_reg;
  logic [31:0] mem_q [0:7];
  // valid drops with the request, as a real memory would
  assign o_rd_valid = i_rd_req && req_reg;
  assign o_rd_data  = o_rd_valid ? {~i_rd_addr, i_rd_addr} : {i_rd_addr, 13'h0, cyc_reg};
  // long stalls let the fifo fill up
  assign o_wr_ready = !i_slow || (cyc_reg == 3'h7);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cyc_reg <= 3'h0;
      req_reg <= 1'b0;
      o_wr_cnt <= 0;
    end else begin
      cyc_reg <= cyc_reg + 3'h1;
      req_reg <= i_rd_req;
      if (i_wr_valid && o_wr_ready) begin
        mem_q[i_wr_addr[2:0]] <= i_wr_data;
        o_wr_cnt <= o_wr_cnt + 1;
      end
    end
  end
endmodule // sss_mem_model

/* File: sss_top_tb.sv */
// Purpose: self-checking bench for the start sequencer
// Assumes: short settle and probe counts
// Notes:   inputs change at the falling edge
`include "sss_defs.vh"
module sss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 40;
  localparam int PROBE  = 20;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wakeup = 1'b0, i_cmp_high_battery = 1'b0;
  logic i_cmp_low_battery = 1'b0, i_ldo_settled = 1'b0, i_xtal_settled = 1'b0;
  logic i_timeout_inhibit = 1'b0, i_otp_copy_en = 1'b0, i_word_count_load = 1'b0;
  logic i_user_spi_sel = 1'b0, i_flash_wake_prog = 1'b0, i_probe_reply = 1'b0;
  logic i_loader_done = 1'b0, i_loader_fail = 1'b0, i_slow = 1'b0;
  logic [15:0] i_word_count = 16'h0;
  logic [63:0] i_app_flag = 64'h0;
  logic [31:0] i_cal_flags = 32'h0;
  logic [7:0]  i_flash_wake_opc = 8'h0;
  wire o_otp_rd_req, o_ram_wr_valid, o_dcdc_en, o_dcdc_boost, o_bandgap_en, o_ldo_en;
  wire o_xtal_en, o_cold_start, o_cpu_run, o_boot_active, o_periph_en, o_hdr_cfg_wr;
  wire o_cal_valid, o_user_spi_active, o_probe_send, o_loader_run, i_otp_rd_valid, i_ram_wr_ready;
  wire [15:0] o_otp_rd_addr, o_ram_wr_addr;
  wire [31:0] o_ram_wr_data, i_otp_rd_data;
  wire [1:0]  o_boot_mode, o_slave_iter;
  wire [7:0]  o_flash_wake_opc, o_pin_map;
  wire [3:0]  o_search_step;
  wire [2:0]  o_if_sel;
  wire [17:0] o_rate_kbd;
  int failures = 0, n_tests = 0, cycles = 0, wr_cnt, exp_cnt, k;
  logic [3:0] st;
  logic [1:0] it;
  logic [2:0] sel;
  logic [7:0] pin;
  logic [17:0] rate;
  // step, iteration, interface, pins, rate (0 for spi master steps)
  logic [34:0] rows [15] = '{{4'h0, 2'h0, 3'h1, 8'h03, 18'h0}, {4'h1, 2'h0, 3'h1, 8'h01, 18'h0},
    {4'h2, 2'h0, 3'h2, 8'h01, 18'hE100}, {4'h3, 2'h0, 3'h2, 8'h23, 18'h1C200},
    {4'h4, 2'h0, 3'h2, 8'h45, 18'hE100}, {4'h5, 2'h0, 3'h2, 8'h67, 18'h2580},
    {4'h6, 2'h0, 3'h3, 8'h03, 18'h1F40}, {4'h6, 2'h1, 3'h3, 8'h03, 18'hFA0},
    {4'h6, 2'h2, 3'h3, 8'h03, 18'h7D0}, {4'h6, 2'h3, 3'h3, 8'h03, 18'h3E8},
    {4'h7, 2'h0, 3'h4, 8'h01, 18'h64}, {4'h8, 2'h0, 3'h4, 8'h23, 18'h64},
    {4'h9, 2'h0, 3'h4, 8'h45, 18'h64}, {4'hA, 2'h0, 3'h4, 8'h67, 18'h64},
    {4'h0, 2'h0, 3'h1, 8'h03, 18'h0}};
  sss_top #(.SETTLE_TMO_CYC(SETTLE), .PROBE_TMO_CYC(PROBE)) dut (.i_clk, .i_rst_b, .i_wakeup,
    .i_cmp_high_battery, .i_cmp_low_battery, .i_ldo_settled, .i_xtal_settled, .i_timeout_inhibit,
    .i_otp_copy_en, .i_word_count_load, .i_word_count, .o_otp_rd_req, .o_otp_rd_addr,
    .i_otp_rd_valid, .i_otp_rd_data, .o_ram_wr_valid, .o_ram_wr_addr, .o_ram_wr_data,
    .i_ram_wr_ready, .i_app_flag, .i_cal_flags, .i_user_spi_sel, .i_flash_wake_opc,
    .i_flash_wake_prog, .i_probe_reply, .i_loader_done, .i_loader_fail, .o_dcdc_en,
    .o_dcdc_boost, .o_bandgap_en, .o_ldo_en, .o_xtal_en, .o_cold_start, .o_cpu_run,
    .o_boot_active, .o_boot_mode, .o_periph_en, .o_hdr_cfg_wr, .o_cal_valid, .o_flash_wake_opc,
    .o_user_spi_active, .o_search_step, .o_slave_iter, .o_if_sel, .o_pin_map, .o_rate_kbd,
    .o_probe_send, .o_loader_run);
  sss_mem_model u_mem (.i_clk, .i_rst_b, .i_slow, .i_rd_req(o_otp_rd_req),
    .i_rd_addr(o_otp_rd_addr), .o_rd_valid(i_otp_rd_valid), .o_rd_data(i_otp_rd_data),
    .i_wr_valid(o_ram_wr_valid), .i_wr_addr(o_ram_wr_addr), .i_wr_data(o_ram_wr_data),
    .o_wr_ready(i_ram_wr_ready), .o_wr_cnt(wr_cnt));
  always #4 i_clk = ~i_clk;
  // --------
  // helpers
  // --------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // stops a hung run; normal run is well under this
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return o_boot_active;
      1: return o_cpu_run;
      2: return o_loader_run;
      3: return o_user_spi_active;
      4: return !o_user_spi_active;
      6: return o_hdr_cfg_wr;
      7: return o_otp_rd_req;
      default: return wr_cnt == exp_cnt;
    endcase
  endfunction
  task automatic wait_on(input int w, input int lim);
    k = 0;
    while (cond(w) !== 1'b1 && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    cmp_val(cond(w), 1'b1);
  endtask
  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (10) @(negedge i_clk);
    cmp_val({o_cold_start, o_cpu_run, o_boot_active, o_xtal_en}, 4'h8);
    i_rst_b = 1'b1;
  endtask
  task automatic wake(input logic en, input int n);
    i_otp_copy_en = en;
    exp_cnt = n;
    i_wakeup = 1'b1;
    @(negedge i_clk);
    i_wakeup = 1'b0;
  endtask
  // --------
  // scenarios
  // --------
  initial begin
    i_cmp_low_battery = 1'b1;
    i_user_spi_sel = 1'b1;
    i_flash_wake_prog = 1'b1;
    i_flash_wake_opc = 8'h5C;
    do_reset();
    wait_on(0, SETTLE + 30);
    @(negedge i_clk);
    cmp_val(o_cold_start, 1'b0);
    cmp_val(o_dcdc_boost, 1'b1);
    cmp_val({o_dcdc_en, o_bandgap_en, o_ldo_en, o_xtal_en}, 4'hF);
    cmp_val(o_boot_mode, `SSS_MODE_DEV);
    wait_on(3, 20);
    cmp_val(o_flash_wake_opc, 8'h5C);
    wait_on(4, PROBE + 40);
    for (int r = 0; r < 15; r++) begin
      {st, it, sel, pin, rate} = rows[r];
      k = 0;
      while (!(o_search_step === st && o_slave_iter === it) && k < 300) begin
        @(negedge i_clk);
        k++;
      end
      // pins and rate follow the step one cycle later
      @(negedge i_clk);
      cmp_val(o_if_sel, sel);
      cmp_val(o_pin_map, pin);
      cmp_val(o_rate_kbd, rate);
      cmp_val(o_probe_send, 1'b1);
    end
    i_probe_reply = 1'b1;
    wait_on(2, PROBE + 40);
    i_loader_fail = 1'b1;
    @(negedge i_clk);
    i_loader_fail = 1'b0;
    cmp_val(o_loader_run, 1'b0);
    wait_on(2, PROBE + 40);
    i_loader_done = 1'b1;
    repeat (4) @(negedge i_clk);
    cmp_val(o_loader_run, 1'b0);
    {i_probe_reply, i_loader_done} = 2'h0;
    $display("dev search test done");
    i_cmp_low_battery = 1'b0;
    i_cmp_high_battery = 1'b1;
    i_timeout_inhibit = 1'b1;
    i_user_spi_sel = 1'b0;
    i_flash_wake_prog = 1'b0;
    i_app_flag = `SSS_APP_FLAG;
    i_cal_flags = 32'hA5A50F0F;
    do_reset();
    repeat (3 * SETTLE) @(negedge i_clk);
    cmp_val(o_boot_active, 1'b0);
    i_ldo_settled = 1'b1;
    i_xtal_settled = 1'b1;
    wait_on(0, 20);
    cmp_val(o_boot_mode, `SSS_MODE_NORMAL);
    cmp_val(o_dcdc_boost, 1'b0);
    wait_on(6, 50);
    wait_on(1, 200);
    cmp_val(o_cal_valid, 1'b1);
    cmp_val(o_flash_wake_opc, `SSS_FLASH_WAKE_DEF);
    i_word_count = 16'h0005;
    i_word_count_load = 1'b1;
    @(negedge i_clk);
    i_word_count_load = 1'b0;
    $display("normal boot test done");
    i_slow = 1'b1;
    i_cmp_low_battery = 1'b1;
    i_timeout_inhibit = 1'b0;
    wake(1'b1, 5);
    wait_on(7, 40);
    cmp_val({o_boot_active, o_dcdc_boost}, 2'h0);
    wait_on(8, 400);
    repeat (30) @(negedge i_clk);
    cmp_val(wr_cnt, 5);
    for (int a = 0; a < 5; a++) cmp_val(u_mem.mem_q[a], {~16'(a), 16'(a)});
    cmp_val({o_cpu_run, o_cold_start}, 2'h2);
    wake(1'b0, 5);
    repeat (60) @(negedge i_clk);
    cmp_val({wr_cnt, o_cpu_run}, {32'd5, 1'b1});
    i_slow = 1'b0;
    wake(1'b1, 10);
    wait_on(8, 200);
    repeat (20) @(negedge i_clk);
    cmp_val(wr_cnt, 10);
    $display("wake copy test done");
    i_app_flag = `SSS_APP_FLAG ^ 64'h1;
    do_reset();
    wait_on(0, SETTLE + 30);
    repeat (3) @(negedge i_clk);
    cmp_val({o_boot_mode, o_periph_en}, {`SSS_MODE_FAULT, 1'b1});
    $display("fault boot test done");
    end_sim();
  end
endmodule // sss_top_tb
bind sss_top sss_top_props #(.SETTLE_TMO_CYC(SETTLE_TMO_CYC)) u_props (.i_clk, .i_rst_b,
  .i_cmp_low_battery, .i_cmp_high_battery, .i_timeout_inhibit, .o_xtal_en, .o_dcdc_boost,
  .o_cold_start, .o_cpu_run, .o_boot_active, .o_boot_mode, .o_periph_en, .o_hdr_cfg_wr,
  .o_otp_rd_req, .o_user_spi_active, .o_search_step, .o_slave_iter, .o_if_sel, .o_rate_kbd,
  .o_loader_run);
